// [pem_generator.sv]
// file: top of the pwm edge mode generator with counter and registers
`timescale 1ns/1ns
//
// Overview of operation
// - period counter counts zero to limit, wraps
// - signals toggle when counter equals target
// - multiple mode: two phases, same duty, offset
// - multiple mode ignores events two and four
// - multiple: b may wrap, a never does
// - multiple: a from ev1 to ev1+duty+adj+comp
// - multiple: b from ev3 to ev3+duty+adj+comp
// - multiple: blanking b runs from its begin to its end register
// - adaptive triggers at duty and half duty
// - phase trigger from register or duty
// - sample and blanking points straight from registers
// - resonant subtracts mean dead time from duty
// - resonant symmetric edges around compensated duty
// - triangular: no output a, no adaptive trigger
// - triangular: b centred on half period
// - leading: a other edge moves earlier
// - leading: b from ev4, dead-time offset
// - leading: adaptive triggers before event one
module pem_generator #(
  parameter int CNT_W = pem_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // loop filter outputs
  input wire logic [CNT_W-1:0] filt_duty,
  input wire logic [CNT_W-1:0] filt_period,
  // dead times used by resonant compensation
  input wire logic [CNT_W-1:0] dead_a,
  input wire logic [CNT_W-1:0] dead_b,
  // gate driver outputs and triggers
  output logic pulse_output_a,
  output logic pulse_output_b,
  output logic adapt_trig_a,
  output logic adapt_trig_b,
  output logic phase_trig,
  output logic samp_trig_1,
  output logic samp_trig_2,
  output logic blank_a,
  output logic blank_b,
  output logic period_start
);
  initial begin
    if (CNT_W != pem_pkg::CNT_W) $error("CNT_W must equal package width");
  end

  pem_pkg::pem_bus_type bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // software registers
  logic [15:0] regs_q [0:16];
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  pem_pkg::pem_mode_type mode_q;
  pem_pkg::pem_mode_type mode_d;
  logic [CNT_W-1:0] period_q;
  pem_pkg::pem_edges_type edges;
  logic [15:0] rdata_d;

  wire logic [15:0] ctrl = regs_q[pem_pkg::ADDR_CTRL];
  wire logic run = ctrl[pem_pkg::CTRL_EN_BIT];
  wire logic [1:0] mode_sel =
    ctrl[pem_pkg::CTRL_MODE_LSB +: pem_pkg::CTRL_MODE_W];
  wire logic at_limit = (cnt_q >= period_q);
  wire logic wrap_now = run & at_limit;

  function automatic pem_pkg::pem_mode_type decode(input logic [1:0] m);
    case (m)
      pem_pkg::MODE_MULTI: decode = pem_pkg::PEM_MULTI;
      pem_pkg::MODE_RESONANT: decode = pem_pkg::PEM_RESON;
      pem_pkg::MODE_TRIANGLE: decode = pem_pkg::PEM_TRI;
      pem_pkg::MODE_LEADING: decode = pem_pkg::PEM_LEAD;
      default: decode = pem_pkg::PEM_MULTI;
    endcase
  endfunction : decode

  function automatic logic hit(input logic [CNT_W-1:0] c,
                               input logic [15:0] t);
    hit = (c == t[CNT_W-1:0]);
  endfunction : hit

  assign cnt_d = !run ? '0 : (at_limit ? '0 : cnt_q + 1'b1);
  // period and mode latched together so no runt pulses arise
  assign mode_d = (wrap_now || !run) ? decode(mode_sel) : mode_q;

  pem_edge_calc #(
    .W(CNT_W)
  ) u_calc (
    .mode(mode_q),
    .period_limit(period_q),
    .ev1(regs_q[pem_pkg::ADDR_EV1]),
    .ev2(regs_q[pem_pkg::ADDR_EV2]),
    .ev3(regs_q[pem_pkg::ADDR_EV3]),
    .ev4(regs_q[pem_pkg::ADDR_EV4]),
    .filt_duty(filt_duty),
    .filt_period(filt_period),
    .cyc_a(regs_q[pem_pkg::ADDR_CYC_A]),
    .cyc_b(regs_q[pem_pkg::ADDR_CYC_B]),
    .dead_time_comp(regs_q[pem_pkg::ADDR_DTC]),
    .adapt_ofs(regs_q[pem_pkg::ADDR_ADAPT]),
    .dead_a(dead_a),
    .dead_b(dead_b),
    .edges(edges)
  );

  // edge hits against the running count
  wire logic hit_ra = run & edges.en_a & hit(cnt_q, edges.rise_a);
  wire logic hit_fa = run & edges.en_a & hit(cnt_q, edges.fall_a);
  wire logic hit_rb = run & hit(cnt_q, edges.rise_b);
  wire logic hit_fb = run & hit(cnt_q, edges.fall_b);
  wire logic hit_ada = run & edges.en_adapt & hit(cnt_q, edges.adapt_a);
  wire logic hit_adb = run & edges.en_adapt & hit(cnt_q, edges.adapt_b);
  wire logic [15:0] phase_tgt = ctrl[pem_pkg::CTRL_PHSEL_BIT] ?
    16'(filt_duty) : regs_q[pem_pkg::ADDR_PHASE];
  wire logic hit_ph = run & hit(cnt_q, phase_tgt);
  wire logic hit_s1 = run & hit(cnt_q, regs_q[pem_pkg::ADDR_SAMP1]);
  wire logic hit_s2 = run & hit(cnt_q, regs_q[pem_pkg::ADDR_SAMP2]);
  wire logic hit_bab = run & hit(cnt_q, regs_q[pem_pkg::ADDR_BLKA_BEG]);
  wire logic hit_bae = run & hit(cnt_q, regs_q[pem_pkg::ADDR_BLKA_END]);
  wire logic hit_bbb = run & hit(cnt_q, regs_q[pem_pkg::ADDR_BLKB_BEG]);
  wire logic hit_bbe = run & hit(cnt_q, regs_q[pem_pkg::ADDR_BLKB_END]);
  // output a is forced low at wrap so it cannot cross the boundary
  wire logic a_d = !run || !edges.en_a ? 1'b0 :
    (hit_fa || wrap_now) ? 1'b0 : (hit_ra ? 1'b1 : pulse_output_a);
  // output b keeps its state across the wrap in multiple mode
  wire logic b_d = !run ? 1'b0 :
    (hit_rb && !hit_fb) ? 1'b1 :
    (hit_fb && !hit_rb) ? 1'b0 : pulse_output_b;
  wire logic ba_d = !run ? 1'b0 :
    hit_bab ? 1'b1 : (hit_bae ? 1'b0 : blank_a);
  wire logic bb_d = !run ? 1'b0 :
    hit_bbb ? 1'b1 : (hit_bbe ? 1'b0 : blank_b);

  // read selection; unmapped addresses read zero
  always_comb begin
    rdata_d = pem_pkg::ZERO16;
    if (bus.addr < pem_pkg::ADDR_STATUS)
      rdata_d = regs_q[bus.addr];
    else if (bus.addr == pem_pkg::ADDR_STATUS)
      rdata_d = {10'h000, mode_q, pulse_output_b, pulse_output_a};
    else if (bus.addr == pem_pkg::ADDR_COUNT)
      rdata_d = 16'(cnt_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 17; i++) begin
        regs_q[i] <= pem_pkg::ZERO16;
      end
    end else if (bus.wr && bus.addr < pem_pkg::ADDR_STATUS) begin
      regs_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      mode_q <= pem_pkg::PEM_MULTI;
      period_q <= pem_pkg::PERIOD_RESET[CNT_W-1:0];
    end else begin
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      if (wrap_now || !run)
        period_q <= regs_q[pem_pkg::ADDR_PERIOD][CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_output_a <= 1'b0;
      pulse_output_b <= 1'b0;
      blank_a <= 1'b0;
      blank_b <= 1'b0;
      adapt_trig_a <= 1'b0;
      adapt_trig_b <= 1'b0;
      phase_trig <= 1'b0;
      samp_trig_1 <= 1'b0;
      samp_trig_2 <= 1'b0;
      period_start <= 1'b0;
      reg_rdata <= pem_pkg::ZERO16;
    end else begin
      pulse_output_a <= a_d;
      pulse_output_b <= b_d;
      blank_a <= ba_d;
      blank_b <= bb_d;
      adapt_trig_a <= hit_ada;
      adapt_trig_b <= hit_adb;
      phase_trig <= hit_ph;
      samp_trig_1 <= hit_s1;
      samp_trig_2 <= hit_s2;
      period_start <= wrap_now;
      reg_rdata <= bus.rd ? rdata_d : pem_pkg::ZERO16;
    end
  end
endmodule : pem_generator

// [pem_pkg.sv]
// package: constants and types for the pwm edge mode generator
package pem_pkg;
  localparam int CNT_W = 16;
  // register offsets (word index == byte address / 4 not used; plain port)
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PERIOD = 5'h01;
  localparam logic [4:0] ADDR_EV1 = 5'h02;
  localparam logic [4:0] ADDR_EV2 = 5'h03;
  localparam logic [4:0] ADDR_EV3 = 5'h04;
  localparam logic [4:0] ADDR_EV4 = 5'h05;
  localparam logic [4:0] ADDR_CYC_A = 5'h06;
  localparam logic [4:0] ADDR_CYC_B = 5'h07;
  localparam logic [4:0] ADDR_DTC = 5'h08;
  localparam logic [4:0] ADDR_ADAPT = 5'h09;
  localparam logic [4:0] ADDR_PHASE = 5'h0a;
  localparam logic [4:0] ADDR_SAMP1 = 5'h0b;
  localparam logic [4:0] ADDR_SAMP2 = 5'h0c;
  localparam logic [4:0] ADDR_BLKA_BEG = 5'h0d;
  localparam logic [4:0] ADDR_BLKA_END = 5'h0e;
  localparam logic [4:0] ADDR_BLKB_BEG = 5'h0f;
  localparam logic [4:0] ADDR_BLKB_END = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h11;
  localparam logic [4:0] ADDR_COUNT = 5'h12;
  localparam logic [4:0] NUM_REGS = 5'h13;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_PHSEL_BIT = 2;
  localparam int CTRL_ADSEL_BIT = 3;
  localparam int CTRL_EN_BIT = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h00ff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // operating mode codes
  localparam logic [1:0] MODE_MULTI = 2'h0;
  localparam logic [1:0] MODE_RESONANT = 2'h1;
  localparam logic [1:0] MODE_TRIANGLE = 2'h2;
  localparam logic [1:0] MODE_LEADING = 2'h3;

  typedef enum logic [3:0] {
    PEM_MULTI = 4'h1,
    PEM_RESON = 4'h2,
    PEM_TRI = 4'h4,
    PEM_LEAD = 4'h8
  } pem_mode_type;

  typedef struct packed {
    logic [15:0] rise_a;
    logic [15:0] fall_a;
    logic [15:0] rise_b;
    logic [15:0] fall_b;
    logic [15:0] adapt_a;
    logic [15:0] adapt_b;
    logic en_a;
    logic en_adapt;
  } pem_edges_type;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pem_bus_type;
endpackage : pem_pkg

// [pem_edge_calc.sv]
// file: combinational edge equations for every operating mode
`timescale 1ns/1ns
module pem_edge_calc #(
  parameter int W = 16
) (
  // selected mode
  input wire pem_pkg::pem_mode_type mode,
  // timing operands
  input wire logic [W-1:0] period_limit,
  input wire logic [W-1:0] ev1,
  input wire logic [W-1:0] ev2,
  input wire logic [W-1:0] ev3,
  input wire logic [W-1:0] ev4,
  input wire logic [W-1:0] filt_duty,
  input wire logic [W-1:0] filt_period,
  input wire logic signed [W-1:0] cyc_a,
  input wire logic signed [W-1:0] cyc_b,
  input wire logic signed [W-1:0] dead_time_comp,
  input wire logic signed [W-1:0] adapt_ofs,
  input wire logic [W-1:0] dead_a,
  input wire logic [W-1:0] dead_b,
  // targets
  output pem_pkg::pem_edges_type edges
);
  initial begin
    if (W != pem_pkg::CNT_W) $error("pem_edge_calc width must match CNT_W");
  end

  // signed sums kept two bits wider so clamping sees true over/underflow
  function automatic logic [W-1:0] sat(input logic signed [W+1:0] v,
                                       input logic [W-1:0] lim);
    if (v < 0)
      sat = '0;
    else if (v > $signed({2'b00, lim}))
      sat = lim;
    else
      sat = v[W-1:0];
  endfunction : sat

  // wrap across the period for output b in multiple mode
  function automatic logic [W-1:0] wrap(input logic signed [W+1:0] v,
                                        input logic [W-1:0] lim);
    logic signed [W+1:0] p;
    p = $signed({2'b00, lim});
    p = p + 1'b1;
    if (v < 0)
      wrap = W'(v + p);
    else if (v > $signed({2'b00, lim}))
      wrap = W'(v - p);
    else
      wrap = v[W-1:0];
  endfunction : wrap

  function automatic logic signed [W+1:0] u(input logic [W-1:0] x);
    u = $signed({2'b00, x});
  endfunction : u

  function automatic logic signed [W+1:0] s(input logic signed [W-1:0] x);
    s = {{2{x[W-1]}}, x};
  endfunction : s

  wire logic signed [W+1:0] duty_res = u(filt_duty)
    - ((u(dead_a) + u(dead_b)) >>> 1);
  wire logic signed [W+1:0] half_duty = u(filt_duty) >>> 1;
  wire logic signed [W+1:0] half_prd = u(period_limit) >>> 1;
  wire logic signed [W+1:0] lead_base = u(ev1) - u(filt_duty) + s(cyc_a);

  always_comb begin
    edges = '0;
    case (mode)
      pem_pkg::PEM_MULTI: begin
        edges.en_a = 1'b1;
        edges.en_adapt = 1'b1;
        edges.rise_a = ev1;
        edges.fall_a = sat(u(ev1) + u(filt_duty) + s(cyc_a)
          + s(dead_time_comp), period_limit);
        edges.rise_b = ev3;
        edges.fall_b = wrap(u(ev3) + u(filt_duty) + s(cyc_b)
          + s(dead_time_comp), period_limit);
        edges.adapt_a = sat(u(ev1) + u(filt_duty) + s(adapt_ofs),
          period_limit);
        edges.adapt_b = sat(u(ev1) + half_duty + s(adapt_ofs),
          period_limit);
      end
      pem_pkg::PEM_RESON: begin
        edges.en_a = 1'b1;
        edges.en_adapt = 1'b1;
        edges.rise_a = ev1;
        edges.fall_a = sat(duty_res - u(ev1), period_limit);
        edges.rise_b = sat(duty_res + u(ev1), period_limit);
        edges.fall_b = sat(u(filt_period) - u(ev1), period_limit);
        edges.adapt_a = sat(u(ev1) + u(filt_duty) + s(adapt_ofs),
          period_limit);
        edges.adapt_b = sat(u(ev1) + half_duty + s(adapt_ofs),
          period_limit);
      end
      pem_pkg::PEM_TRI: begin
        edges.en_a = 1'b0;
        edges.en_adapt = 1'b0;
        edges.rise_b = sat(half_prd - half_duty + s(cyc_a),
          period_limit);
        edges.fall_b = sat(half_prd + half_duty + s(cyc_b),
          period_limit);
      end
      pem_pkg::PEM_LEAD: begin
        edges.en_a = 1'b1;
        edges.en_adapt = 1'b1;
        // falling edge fixed, rising edge moves earlier as duty grows
        edges.rise_a = sat(lead_base, period_limit);
        edges.fall_a = ev1;
        edges.rise_b = ev4;
        edges.fall_b = sat(lead_base - (u(ev2) - u(ev3)),
          period_limit);
        edges.adapt_a = sat(u(ev1) - u(filt_duty) + s(adapt_ofs),
          period_limit);
        edges.adapt_b = sat(u(ev1) - half_duty + s(adapt_ofs),
          period_limit);
      end
      default: edges = '0;
    endcase
  end
endmodule : pem_edge_calc

// [pem_gate_driver_model.sv]
// gate driver model: measures the on-time of each drive in cycles
`timescale 1ns/1ns
module pem_gate_driver_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // drive from the generator, clear forgets old widths
  input wire logic drive_a,
  input wire logic drive_b,
  input wire logic clear,
  // last completed on-time
  output logic [15:0] width_a,
  output logic [15:0] width_b
);
  logic [15:0] run_a_q;
  logic [15:0] run_b_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_a_q <= 16'h0000;
      run_b_q <= 16'h0000;
      width_a <= 16'h0000;
      width_b <= 16'h0000;
    end else if (clear) begin
      run_a_q <= 16'h0000;
      run_b_q <= 16'h0000;
      width_a <= 16'h0000;
      width_b <= 16'h0000;
    end else begin
      run_a_q <= drive_a ? run_a_q + 16'h0001 : 16'h0000;
      run_b_q <= drive_b ? run_b_q + 16'h0001 : 16'h0000;
      if (!drive_a && run_a_q != 16'h0000) width_a <= run_a_q;
      if (!drive_b && run_b_q != 16'h0000) width_b <= run_b_q;
    end
  end
endmodule : pem_gate_driver_model

// [pem_checker.sv]
// checker: edge placement assertions on the generator ports
`timescale 1ns/1ns
module pem_checker (
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // timed outputs
  input wire logic pulse_output_a,
  input wire logic pulse_output_b,
  input wire logic adapt_trig_a,
  input wire logic adapt_trig_b,
  input wire logic samp_trig_1,
  input wire logic samp_trig_2,
  input wire logic blank_a,
  input wire logic period_start
);
  logic [15:0] sh_q [0:16];
  logic [15:0] since_q;
  logic [1:0] quiet_q;
  // settings reload at wrap, so only judge after two quiet periods
  wire ok = quiet_q == 2'h2;
  wire [1:0] mode = sh_q[0][1:0];
  wire [15:0] per = sh_q[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 17; i++) begin
        sh_q[i] <= 16'h0000;
      end
      since_q <= 16'h0000;
      quiet_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr < 5'h11) sh_q[reg_addr] <= reg_wdata;
      since_q <= period_start ? 16'h0001 : since_q + 16'h0001;
      if (reg_wr) quiet_q <= 2'h0;
      else if (period_start && !ok) quiet_q <= quiet_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_period_span: assert property (
    period_start && ok |-> since_q == per + 16'h0001)
    else $error("period length differs from limit");
  a_samp1_place: assert property (
    samp_trig_1 && ok && sh_q[11] < per |->
    since_q == sh_q[11] + 16'h0001)
    else $error("sample one misplaced");
  a_samp2_place: assert property (
    samp_trig_2 && ok && sh_q[12] < per |->
    since_q == sh_q[12] + 16'h0001)
    else $error("sample two misplaced");
  a_blank_a_begin: assert property (
    $rose(blank_a) && ok && sh_q[13] < per |->
    since_q == sh_q[13] + 16'h0001)
    else $error("blank a begins off target");
  a_a_rise_event: assert property (
    $rose(pulse_output_a) && ok && mode != pem_pkg::MODE_LEADING &&
    sh_q[2] < per |-> since_q == sh_q[2] + 16'h0001)
    else $error("output a rises off event one");
  a_lead_fall_a: assert property (
    $fell(pulse_output_a) && ok && mode == pem_pkg::MODE_LEADING &&
    sh_q[2] < per |-> since_q == sh_q[2] + 16'h0001)
    else $error("output a falls off event one");
  a_multi_rise_b: assert property (
    $rose(pulse_output_b) && ok && mode == pem_pkg::MODE_MULTI &&
    sh_q[4] < per |-> since_q == sh_q[4] + 16'h0001)
    else $error("output b rises off event three");
  a_lead_rise_b: assert property (
    $rose(pulse_output_b) && ok && mode == pem_pkg::MODE_LEADING &&
    sh_q[5] < per |-> since_q == sh_q[5] + 16'h0001)
    else $error("output b rises off event four");
  a_tri_quiet_a: assert property (
    ok && mode == pem_pkg::MODE_TRIANGLE |->
    !pulse_output_a && !adapt_trig_a && !adapt_trig_b)
    else $error("output a or adaptive trigger active");
  c_triangle: cover property (ok && mode == pem_pkg::MODE_TRIANGLE);
  c_b_rise: cover property ($rose(pulse_output_b) && ok);
  c_samp1: cover property (samp_trig_1 && ok);
endmodule : pem_checker
bind pem_generator pem_checker pem_checker_inst (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .pulse_output_a(pulse_output_a), .pulse_output_b(pulse_output_b),
  .adapt_trig_a(adapt_trig_a), .adapt_trig_b(adapt_trig_b),
  .samp_trig_1(samp_trig_1), .samp_trig_2(samp_trig_2),
  .blank_a(blank_a), .period_start(period_start));

// [testbench.sv]
// testbench: register setup, two runs in multiple mode and one in each other mode, width and offset checks
`timescale 1ns/1ns
module testbench;
  logic clk, rst_n, reg_wr, reg_rd, clear;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, filt_duty, filt_period, dead_a, dead_b;
  logic [15:0] width_a, width_b;
  // 0 a, 1 b, 2/3 adaptive, 4 phase, 5/6 sample, 7/8 blank, 9 start
  logic [9:0] trig;
  int error_cnt, n_checks;
  pem_generator pem_generator_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filt_duty(filt_duty),
    .filt_period(filt_period), .dead_a(dead_a), .dead_b(dead_b),
    .pulse_output_a(trig[0]), .pulse_output_b(trig[1]),
    .adapt_trig_a(trig[2]), .adapt_trig_b(trig[3]), .phase_trig(trig[4]),
    .samp_trig_1(trig[5]), .samp_trig_2(trig[6]), .blank_a(trig[7]),
    .blank_b(trig[8]), .period_start(trig[9]));
  pem_gate_driver_model pem_gate_driver_model_inst (.clk(clk),
    .rst_n(rst_n), .drive_a(trig[0]), .drive_b(trig[1]), .clear(clear),
    .width_a(width_a), .width_b(width_b));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic starts(input int n);
    for (int k = 0; k < n; k++) begin
      int t;
      t = 0;
      do begin
        @(posedge clk);
        #1 t++;
      end while (trig[9] !== 1'b1 && t < 300);
      if (t >= 300) begin
        error_cnt++;
        report_and_stop();
      end
    end
  endtask : starts
  // cycles from period start to the first pulse of one output
  task automatic offset(input int b, output logic [15:0] n);
    starts(1);
    n = 16'h0000;
    while (trig[b] !== 1'b1 && n < 16'h00c8) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : offset
  task automatic go(input logic [15:0] ctrl, input logic [15:0] sts,
                    input logic [15:0] d, input logic [15:0] e1,
                    input logic [15:0] e3, input logic [15:0] ca,
                    input logic [15:0] cb);
    logic [15:0] v;
    @(posedge clk);
    filt_duty <= d;
    wr(pem_pkg::ADDR_EV1, e1);
    wr(pem_pkg::ADDR_EV3, e3);
    wr(pem_pkg::ADDR_CYC_A, ca);
    wr(pem_pkg::ADDR_CYC_B, cb);
    wr(pem_pkg::ADDR_CTRL, ctrl);
    clear <= 1'b1;
    starts(2);
    clear <= 1'b0;
    starts(2);
    rd(pem_pkg::ADDR_STATUS, v);
    check("mode", sts, v & 16'hfffc);
  endtask : go
  task automatic t_reset();
    logic [15:0] v;
    rd(pem_pkg::ADDR_PERIOD, v);
    check("period reset", 16'h0000, v);
    rd(pem_pkg::ADDR_STATUS, v);
    check("status reset", 16'h0004, v);
    rd(5'h15, v);
    check("unmapped", 16'h0000, v);
    wr(pem_pkg::ADDR_PERIOD, 16'h0028);
  endtask : t_reset
  task automatic t_multi();
    logic [15:0] v;
    wr(pem_pkg::ADDR_EV2, 16'h0007);
    wr(pem_pkg::ADDR_EV4, 16'h0009);
    wr(pem_pkg::ADDR_DTC, 16'h0001);
    wr(pem_pkg::ADDR_SAMP1, 16'h000c);
    wr(pem_pkg::ADDR_PHASE, 16'h0009);
    wr(pem_pkg::ADDR_BLKB_BEG, 16'h0013);
    wr(pem_pkg::ADDR_BLKB_END, 16'h0016);
    go(16'h0010, 16'h0004, 16'h0008, 16'h0005, 16'h0014, 16'h0002, 16'h0002);
    check("width a", 16'h000b, width_a);
    check("width b", 16'h000b, width_b);
    offset(5, v);
    check("sample one", 16'h000d, v);
    offset(4, v);
    check("phase reg", 16'h000a, v);
    offset(8, v);
    check("blank b", 16'h0014, v);
    // b wraps across the boundary and keeps its width
    go(16'h0014, 16'h0004, 16'h0008, 16'h0005, 16'h0023, 16'h0002, 16'h0004);
    check("width a", 16'h000b, width_a);
    check("width b wrap", 16'h000d, width_b);
    offset(4, v);
    check("phase duty", 16'h0009, v);
  endtask : t_multi
  task automatic t_res();
    logic [15:0] v;
    go(16'h0011, 16'h0008, 16'h0014, 16'h0003, 16'h0000, 16'h0000, 16'h0000);
    check("width a", 16'h000e, width_a);
    check("width b", 16'h000e, width_b);
    offset(3, v);
    check("adaptive b", 16'h000e, v);
  endtask : t_res
  task automatic t_tri();
    go(16'h0012, 16'h0010, 16'h000a, 16'h0000, 16'h0000, 16'h0001, 16'h0003);
    check("width a", 16'h0000, width_a);
    check("width b", 16'h000c, width_b);
  endtask : t_tri
  task automatic t_lead();
    logic [15:0] v;
    go(16'h0013, 16'h0020, 16'h0008, 16'h001e, 16'h0000, 16'h0000, 16'h0000);
    check("width a", 16'h0008, width_a);
    check("width b", 16'h0006, width_b);
    offset(2, v);
    check("adaptive a", 16'h0017, v);
  endtask : t_lead
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    clear = 1'b0;
    filt_duty = 16'h0000;
    filt_period = 16'h0028;
    dead_a = 16'h0000;
    dead_b = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_multi();
    t_res();
    t_tri();
    t_lead();
    report_and_stop();
  end
endmodule : testbench
